// *** logic/aic_pkg.sv ***
// Package with register map, reset values, formats and types of the analog input block.
package aic_pkg;

    localparam logic [11:0] ADDR_CH_STRIDE = 12'h010;
    localparam logic [11:0] ADDR_LEVEL = 12'h000;
    localparam logic [11:0] ADDR_FUNC = 12'h004;
    localparam logic [11:0] ADDR_GAIN = 12'h008;
    localparam logic [11:0] ADDR_BIAS = 12'h00C;
    localparam logic [11:0] ADDR_FILTER_TC = 12'h020;
    localparam logic [11:0] ADDR_OFFSET1 = 12'h024;
    localparam logic [11:0] ADDR_OFFSET2 = 12'h028;
    localparam logic [11:0] ADDR_SPEED_SRC = 12'h02C;
    localparam logic [11:0] ADDR_MON1 = 12'h030;
    localparam logic [11:0] ADDR_MON2 = 12'h034;

    localparam logic [15:0] LEVEL_UNIPOLAR = 16'h0000;
    localparam logic [15:0] LEVEL_BIPOLAR = 16'h0001;
    localparam logic [15:0] FUNC_SPEED_BIAS = 16'h0000;
    localparam logic [15:0] FUNC_AUX_REF1 = 16'h0002;
    localparam logic [15:0] FUNC_AUX_REF2 = 16'h0003;
    localparam logic [15:0] FUNC_TORQUE_COMP = 16'h0014;
    localparam logic [15:0] FUNC_THROUGH = 16'h001F;
    localparam logic [15:0] FUNC_MAX = 16'h001F;
    localparam logic [15:0] SRC_ANALOG = 16'h0001;

    localparam logic [15:0] RST_FUNC1 = FUNC_SPEED_BIAS;
    localparam logic [15:0] RST_FUNC2 = FUNC_THROUGH;
    localparam logic [15:0] RST_GAIN = 16'h03E8;
    localparam logic [15:0] RST_BIAS = 16'h0000;
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_FILTER_TC = 16'h0003;
    localparam logic [15:0] RST_SPEED_SRC = SRC_ANALOG;

    localparam int PCT_LIMIT = 9999;
    localparam int OFFSET_LIMIT = 500;
    localparam int TC_MAX = 200;
    localparam int SPEED_LIMIT = 1000;
    localparam int VALUE_LIMIT = 32767;
    localparam int FS_SHIFT = 12;
    localparam int FS_COUNTS = 4096;

    localparam int SAMPLE_PERIOD_MS = 1;
    localparam int TC_UNIT_MS = 10;
    localparam int ALPHA_SHIFT = 16;
    localparam logic [16:0] ALPHA_ONE = 17'h10000;
    localparam logic [16:0] RST_ALPHA =
        17'(65536 * SAMPLE_PERIOD_MS / (3 * TC_UNIT_MS + SAMPLE_PERIOD_MS));
    localparam logic [4:0] DIV_STEPS = 5'h11;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FILTER = 2'b01,
        ST_SCALE = 2'b11,
        ST_ROUTE = 2'b10
    } proc_state_t;

    typedef struct packed {
        logic valid;
        logic signed [15:0] first;
        logic signed [15:0] second;
    } sample_t;

    typedef struct packed {
        logic update;
        logic signed [15:0] speed_bias;
        logic aux1_valid;
        logic signed [15:0] aux_ref1;
        logic aux2_valid;
        logic signed [15:0] aux_ref2;
        logic torque_valid;
        logic signed [15:0] torque_comp;
    } ref_out_t;

endpackage

// *** logic/analog_input_conditioning.sv ***
// Two-channel analog input conditioning with APB register access.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module analog_input_conditioning
    import aic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sample_t sample,
    output ref_out_t refs,
    output logic busy
);

    logic [15:0] level_r [2];
    logic [15:0] func_r [2];
    logic signed [15:0] gain_r [2];
    logic signed [15:0] bias_r [2];
    logic signed [15:0] offset_r [2];
    logic [15:0] filter_tc_r;
    logic [15:0] speed_src_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic wr_go;
    logic signed [15:0] wval;
    logic [16:0] alpha_r;
    logic div_busy_r;
    logic [4:0] div_cnt_r;
    logic [11:0] div_den_r;
    logic [12:0] div_rem_r;
    logic [16:0] div_num_r;
    logic [16:0] div_quo_r;
    logic [12:0] div_rem_s;
    proc_state_t state_r;
    logic signed [15:0] xin_r [2];
    logic signed [31:0] filt_r [2];
    logic signed [15:0] chval_r [2];
    ref_out_t refs_r;
    logic busy_r;

    function automatic logic signed [15:0] sat16(input logic signed [33:0] v, input int lim);
        logic signed [33:0] l;
        l = 34'(lim);
        if (v > l) begin
            return 16'(lim);
        end else if (v < -l) begin
            return 16'(-lim);
        end
        return v[15:0];
    endfunction

    function automatic logic in_range(input logic signed [31:0] v, input int lo, input int hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic signed [15:0] scale(input logic signed [15:0] gain,
                                                  input logic signed [15:0] bias,
                                                  input logic signed [15:0] x,
                                                  input logic [15:0] level);
        logic signed [31:0] p;
        logic signed [33:0] s;
        p = gain * x;
        s = 34'(bias) + 34'(p >>> FS_SHIFT);
        if (level == LEVEL_UNIPOLAR && s < 0) begin
            s = '0;
        end
        return sat16(s, VALUE_LIMIT);
    endfunction

    function automatic logic signed [15:0] route_sel(input logic [15:0] f0,
                                                      input logic [15:0] f1,
                                                      input logic [15:0] code,
                                                      input logic signed [15:0] v0,
                                                      input logic signed [15:0] v1);
        if (f0 == code) begin
            return v0;
        end else if (f1 == code) begin
            return v1;
        end
        return '0;
    endfunction

    assign wval = pwdata[15:0];
    assign wr_go = psel && penable && pready_r && pwrite && !pslverr_r;
    assign div_rem_s = {div_rem_r[11:0], div_num_r[16]};

    always_comb begin
        rd_nxt = '0;
        err_nxt = 1'b0;
        case (paddr)
            ADDR_LEVEL, ADDR_LEVEL + ADDR_CH_STRIDE: begin
                rd_nxt = {16'h0000, level_r[paddr[4]]};
                err_nxt = pwrite && !in_range(32'(wval), 0, 1);
            end
            ADDR_FUNC, ADDR_FUNC + ADDR_CH_STRIDE: begin
                rd_nxt = {16'h0000, func_r[paddr[4]]};
                err_nxt = pwrite && !in_range(32'(wval), 0, 32'(FUNC_MAX));
            end
            ADDR_GAIN, ADDR_GAIN + ADDR_CH_STRIDE: begin
                rd_nxt = {16'h0000, gain_r[paddr[4]]};
                err_nxt = pwrite && !in_range(32'(wval), -PCT_LIMIT, PCT_LIMIT);
            end
            ADDR_BIAS, ADDR_BIAS + ADDR_CH_STRIDE: begin
                rd_nxt = {16'h0000, bias_r[paddr[4]]};
                err_nxt = pwrite && !in_range(32'(wval), -PCT_LIMIT, PCT_LIMIT);
            end
            ADDR_FILTER_TC: begin
                rd_nxt = {16'h0000, filter_tc_r};
                err_nxt = pwrite && (div_busy_r || !in_range(32'(wval), 0, TC_MAX));
            end
            ADDR_OFFSET1, ADDR_OFFSET2: begin
                rd_nxt = {16'h0000, offset_r[paddr[3]]};
                err_nxt = pwrite && !in_range(32'(wval), -OFFSET_LIMIT, OFFSET_LIMIT);
            end
            ADDR_SPEED_SRC: begin
                rd_nxt = {16'h0000, speed_src_r};
                err_nxt = pwrite && !in_range(32'(wval), 0, 1);
            end
            ADDR_MON1, ADDR_MON2: begin
                rd_nxt = {16'h0000, chval_r[paddr[2]]};
                err_nxt = pwrite;
            end
            default: begin
                rd_nxt = '0;
                err_nxt = 1'b1;
            end
        endcase
    end

    // Bus answer: registered, ready in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            if (psel && !penable) begin
                prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
                pslverr_r <= err_nxt;
                pready_r <= 1'b1;
            end else begin
                prdata_r <= '0;
                pslverr_r <= 1'b0;
                pready_r <= 1'b0;
            end
        end
    end

    // Settings of both channels, of the shared filter and of the speed source.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r[0] <= LEVEL_UNIPOLAR;
            level_r[1] <= LEVEL_UNIPOLAR;
            func_r[0] <= RST_FUNC1;
            func_r[1] <= RST_FUNC2;
            gain_r[0] <= RST_GAIN;
            gain_r[1] <= RST_GAIN;
            bias_r[0] <= RST_BIAS;
            bias_r[1] <= RST_BIAS;
            offset_r[0] <= RST_OFFSET;
            offset_r[1] <= RST_OFFSET;
            filter_tc_r <= RST_FILTER_TC;
            speed_src_r <= RST_SPEED_SRC;
        end else if (ce && wr_go) begin
            case (paddr)
                ADDR_LEVEL, ADDR_LEVEL + ADDR_CH_STRIDE: begin
                    level_r[paddr[4]] <= wval;
                end
                ADDR_FUNC, ADDR_FUNC + ADDR_CH_STRIDE: begin
                    func_r[paddr[4]] <= wval;
                end
                ADDR_GAIN, ADDR_GAIN + ADDR_CH_STRIDE: begin
                    gain_r[paddr[4]] <= wval;
                end
                ADDR_BIAS, ADDR_BIAS + ADDR_CH_STRIDE: begin
                    bias_r[paddr[4]] <= wval;
                end
                ADDR_FILTER_TC: begin
                    filter_tc_r <= wval;
                end
                ADDR_OFFSET1, ADDR_OFFSET2: begin
                    offset_r[paddr[3]] <= wval;
                end
                ADDR_SPEED_SRC: begin
                    speed_src_r <= wval;
                end
                default: begin
                    speed_src_r <= speed_src_r;
                end
            endcase
        end
    end

    // Filter coefficient: sample period over time constant plus sample period, by division.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alpha_r <= RST_ALPHA;
            div_busy_r <= 1'b0;
            div_cnt_r <= '0;
            div_den_r <= '0;
            div_rem_r <= '0;
            div_num_r <= '0;
            div_quo_r <= '0;
        end else if (ce) begin
            if (wr_go && paddr == ADDR_FILTER_TC) begin
                div_busy_r <= 1'b1;
                div_cnt_r <= DIV_STEPS;
                div_den_r <= 12'(wval * TC_UNIT_MS + SAMPLE_PERIOD_MS);
                div_rem_r <= '0;
                div_num_r <= 17'(ALPHA_ONE * SAMPLE_PERIOD_MS);
                div_quo_r <= '0;
            end else if (div_busy_r) begin
                if (div_rem_s >= {1'b0, div_den_r}) begin
                    div_rem_r <= div_rem_s - {1'b0, div_den_r};
                    div_quo_r <= {div_quo_r[15:0], 1'b1};
                end else begin
                    div_rem_r <= div_rem_s;
                    div_quo_r <= {div_quo_r[15:0], 1'b0};
                end
                div_num_r <= {div_num_r[15:0], 1'b0};
                div_cnt_r <= div_cnt_r - 5'h01;
                if (div_cnt_r == 5'h01) begin
                    div_busy_r <= 1'b0;
                    alpha_r <= (div_rem_s >= {1'b0, div_den_r}) ?
                        {div_quo_r[15:0], 1'b1} : {div_quo_r[15:0], 1'b0};
                end
            end
        end
    end

    // Per-sample processing sequence.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                xin_r[i] <= '0;
                filt_r[i] <= '0;
                chval_r[i] <= '0;
            end
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (sample.valid) begin
                        xin_r[0] <= sat16(34'(sample.first) + 34'(offset_r[0]),
                                          FS_COUNTS);
                        xin_r[1] <= sat16(34'(sample.second) + 34'(offset_r[1]), FS_COUNTS);
                        state_r <= ST_FILTER;
                        busy_r <= 1'b1;
                    end
                end
                ST_FILTER: begin
                    for (int i = 0; i < 2; i++) begin
                        filt_r[i] <= filt_r[i] + 32'((50'($signed({xin_r[i], 16'h0000}))
                            - 50'(filt_r[i])) * 50'($signed({1'b0, alpha_r}))
                            >>> ALPHA_SHIFT);
                    end
                    state_r <= ST_SCALE;
                end
                ST_SCALE: begin
                    for (int i = 0; i < 2; i++) begin
                        chval_r[i] <= scale(gain_r[i], bias_r[i], 16'(filt_r[i] >>> ALPHA_SHIFT),
                                            level_r[i]);
                    end
                    state_r <= ST_ROUTE;
                end
                ST_ROUTE: begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // Function routing of the scaled channel values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refs_r <= '0;
        end else if (ce) begin
            refs_r.update <= 1'b0;
            if (state_r == ST_ROUTE) begin
                refs_r.update <= 1'b1;
                if (speed_src_r == SRC_ANALOG) begin
                    refs_r.speed_bias <= sat16(
                        34'((func_r[0] == FUNC_SPEED_BIAS) ? chval_r[0] : 16'sh0000) +
                        34'((func_r[1] == FUNC_SPEED_BIAS) ? chval_r[1] : 16'sh0000),
                        SPEED_LIMIT);
                end else begin
                    refs_r.speed_bias <= '0;
                end
                refs_r.aux1_valid <= (func_r[0] == FUNC_AUX_REF1) || (func_r[1] == FUNC_AUX_REF1);
                refs_r.aux_ref1 <= sat16(34'(route_sel(func_r[0], func_r[1], FUNC_AUX_REF1,
                    chval_r[0], chval_r[1])), SPEED_LIMIT);
                refs_r.aux2_valid <= (func_r[0] == FUNC_AUX_REF2) || (func_r[1] == FUNC_AUX_REF2);
                refs_r.aux_ref2 <= sat16(34'(route_sel(func_r[0], func_r[1], FUNC_AUX_REF2,
                    chval_r[0], chval_r[1])), SPEED_LIMIT);
                refs_r.torque_valid <= (func_r[0] == FUNC_TORQUE_COMP) ||
                    (func_r[1] == FUNC_TORQUE_COMP);
                refs_r.torque_comp <= route_sel(func_r[0], func_r[1], FUNC_TORQUE_COMP,
                    chval_r[0], chval_r[1]);
                // Through mode and unlisted codes match none of the selectors above.
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign refs = refs_r;
    assign busy = busy_r;

endmodule
`default_nettype wire

// *** verif/analog_input_conditioning_assertions.sv ***
// Port checker for the analog input conditioning block.
`timescale 1ns/10ps
`default_nettype none
module aic_port_checker
    import aic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sample_t sample,
    input wire ref_out_t refs,
    input wire logic busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_setup_answer;
        psel && !penable && ce |=> pready;
    endproperty
    a_setup_answer: assert property (p_setup_answer) else $error("no answer");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_read_idle;
        prdata[31:16] == 16'h0 && (pready || prdata == 32'h0);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("prdata not zero");
    property p_sample_latency;
        sample.valid && !busy && ce |-> ##4 refs.update;
    endproperty
    a_sample_latency: assert property (p_sample_latency) else $error("late update");
    property p_busy_span;
        sample.valid && !busy && ce |=> busy [*3] ##1 !busy;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
    property p_update_pulse;
        refs.update |=> !refs.update;
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("update held");
    property p_hold;
        !refs.update |-> $stable(refs.speed_bias) && $stable(refs.torque_comp);
    endproperty
    a_hold: assert property (p_hold) else $error("refs moved between updates");
    property p_speed_limit;
        refs.speed_bias <= SPEED_LIMIT && refs.speed_bias >= -SPEED_LIMIT;
    endproperty
    a_speed_limit: assert property (p_speed_limit) else $error("speed over limit");
    property p_aux_limit;
        refs.aux_ref1 <= SPEED_LIMIT && refs.aux_ref1 >= -SPEED_LIMIT
            && refs.aux_ref2 <= SPEED_LIMIT && refs.aux_ref2 >= -SPEED_LIMIT;
    endproperty
    a_aux_limit: assert property (p_aux_limit) else $error("aux over limit");
endmodule
`default_nettype wire

// *** verif/analog_input_conditioning_tb_top.sv ***
// Self-checking testbench of the analog input conditioning block.
`timescale 1ns/10ps
`default_nettype none
module analog_input_conditioning_tb_top;
    import aic_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic go = 1'b0;
    logic ce = 1'b1;
    logic signed [15:0] raw1 = 16'h0;
    logic signed [15:0] raw2 = 16'h0;
    sample_t sample;
    ref_out_t refs;
    logic busy;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'h398484AE;
    int cfg[12] = '{0, 0, 1000, 0, 0, 16'h1F, 1000, 0, 3, 0, 0, 1};
    int lim[12] = '{1, -1, 9999, 9999, 1, -1, 9999, 9999, 0, 500, 500, 1};
    int codes[6] = '{0, 2, 3, 16'h14, 16'h1F, 5};
    int bi[13] = '{8, 0, 1, 2, 3, 9, 10, 11, 2, 3, 9, 10, 1};
    int bv[13] = '{201, 2, 32, 10000, -10000, 501, -501, 2, 9999, -9999, 500, -500, 31};
    longint y1 = 0;
    longint y2 = 0;
    longint v1;
    longint v2;
    logic [31:0] rd;
    logic er;
    always #12.5 pclk = ~pclk;
    analog_input_conditioning i_analog_input_conditioning (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample(sample), .refs(refs), .busy(busy));
    analog_source i_analog_source (.pclk(pclk), .presetn(presetn), .go(go), .raw1(raw1),
        .raw2(raw2), .sample(sample));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(32'(n < 16), 32'h1, "pready wait");
        if (n >= 16) test_done();
    endtask
    task automatic wr(input int i, input int val, input logic bad);
        apb(1'b1, 12'(4 * i), 32'(val));
        check(32'(er), 32'(bad), "write status");
        if (!bad) cfg[i] = val;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(rd, exp, nm);
    endtask
    function automatic longint sat(input longint v, input longint l);
        return v > l ? l : (v < -l ? -l : v);
    endfunction
    function automatic longint chan(input longint r, input int o, input int g, input int b,
        input int lv, inout longint y);
        longint x;
        longint v;
        longint al;
        al = cfg[8] == 0 ? 65536 : 65536 / (cfg[8] * 10 + 1);
        x = sat(r + o, 4096);
        y = y + ((((x <<< 16) - y) * al) >>> 16);
        v = b + ((g * (y >>> 16)) >>> 12);
        if (lv == 0 && v < 0) v = 0;
        return sat(v, 32767);
    endfunction
    task automatic rt(input int c, input logic vld, input logic signed [15:0] val,
        input longint l);
        logic hit;
        hit = cfg[1] == c || cfg[5] == c;
        check(32'(vld), 32'(hit), "route valid");
        if (hit) check(32'(val), 32'(sat(cfg[1] == c ? v1 : v2, l)), "route value");
    endtask
    task automatic send(input int a, input int b);
        int n;
        longint sb;
        @(posedge pclk);
        go <= 1'b1;
        raw1 <= 16'(a);
        raw2 <= 16'(b);
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (refs.update !== 1'b1 && n < 16);
        check(32'(n < 16), 32'h1, "update wait");
        if (n >= 16) test_done();
        v1 = chan(a, cfg[9], cfg[2], cfg[3], cfg[0], y1);
        v2 = chan(b, cfg[10], cfg[6], cfg[7], cfg[4], y2);
        sb = (cfg[1] == 0 ? v1 : 0) + (cfg[5] == 0 ? v2 : 0);
        check(32'(refs.speed_bias), 32'(cfg[11] == 1 ? sat(sb, 1000) : 0), "speed");
        rt(2, refs.aux1_valid, refs.aux_ref1, 1000);
        rt(3, refs.aux2_valid, refs.aux_ref2, 1000);
        rt(20, refs.torque_valid, refs.torque_comp, 32767);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rdchk(12'(4 * i), {16'h0, 16'(cfg[i])}, "reset value");
        end
        repeat (3) send(4096, 0);
        @(posedge pclk);
        ce <= 1'b0;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (6) begin
            @(posedge pclk);
            check(32'(refs.update || busy), 32'h0, "frozen sample");
        end
        ce <= 1'b1;
        wr(8, 0, 1'b0);
        wr(8, 0, 1'b1);
        repeat (20) @(posedge pclk);
        for (int i = 0; i < 13; i++) begin
            wr(bi[i], bv[i], i < 8);
            rdchk(12'(4 * bi[i]), {16'h0, 16'(cfg[bi[i]])}, "readback");
        end
        apb(1'b1, ADDR_MON1, 32'h0);
        check(32'(er), 32'h1, "monitor write");
        rdchk(12'h040, 32'h0, "unmapped read");
        check(32'(er), 32'h1, "unmapped status");
        for (int i = 0; i < 24; i++) begin
            for (int j = 0; j < 12; j++) begin
                if (lim[j] < 0) wr(j, codes[$unsigned($random(seed)) % 6], 1'b0);
                else if (lim[j] == 1) wr(j, $unsigned($random(seed)) % 2, 1'b0);
                else if (lim[j] > 1) wr(j, $random(seed) % (lim[j] + 1), 1'b0);
            end
            if (i % 4 == 0) wr(1, 0, 1'b0);
            if (i % 4 == 0) wr(5, 0, 1'b0);
            send($random(seed) % 4097, $random(seed) % 4097);
            rdchk(ADDR_MON1, {16'h0, 16'(v1)}, "first monitor");
            rdchk(ADDR_MON2, {16'h0, 16'(v2)}, "second monitor");
        end
        test_done();
    end
endmodule
bind analog_input_conditioning aic_port_checker i_aic_port_checker (.pclk(pclk),
    .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample(sample), .refs(refs), .busy(busy));
`default_nettype wire

// *** verif/analog_source.sv ***
// Behavioural model of the two analog sources that deliver converted samples.
`timescale 1ns/10ps
`default_nettype none
module analog_source
    import aic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic signed [15:0] raw1,
    input wire logic signed [15:0] raw2,
    output var sample_t sample
);
    // Outside a sample the levels toggle each cycle so stale data never looks held.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample <= '0;
        end else if (go) begin
            sample <= '{valid: 1'b1, first: raw1, second: raw2};
        end else begin
            sample.valid <= 1'b0;
            sample.first <= ~sample.first;
            sample.second <= ~sample.second;
        end
    end
endmodule
`default_nettype wire
